/* File: logic/dfd_frame_decode.sv */
// Contract
// - Data register write runs channel calibration.
// - Without checksum, frame is exactly 24 bits.
// - With checksum, 32 bits, last byte checksum.
// - Fixed field layout: rw, dev, reg, chan, data.
// - Data write loads low 16 bits as code.
// - Accept frame only when device select matches straps.
// - Register select picks data or control register.
// - Select zero writes addressed channel's data only.
// - Decode gain, offset, broadcast, clear, control codes.
// - Channel bits map A to D, else ignored.
`timescale 1ns/1ps
module dfd_frame_decode #(
   parameter int SETTLE_CYCLES = dfd_pkg::SETTLE_CYCLES,
   parameter int CAL_CYCLES = dfd_pkg::CAL_CYCLES
) (
   // System clock and reset.
   input wire logic sys_clk,
   input wire logic arst_n,
   // Serial link.
   input wire logic link_sclk,
   input wire logic link_sync_n,
   input wire logic link_sdin,
   // Strap and option pins.
   input wire logic address_strap_hi,
   input wire logic address_strap_lo,
   input wire logic packet_checksum,
   // Control register write strobe.
   output logic ctrl_wr_pulse,
   output logic [1:0] ctrl_wr_chan,
   output logic [15:0] ctrl_wr_data,
   // Frame status.
   output logic frame_rejected,
   output logic read_req,
   output logic [7:0] frame_checksum_code,
   // Channel status.
   output logic [3:0] cal_busy,
   output logic [3:0] output_enable_safe,
   // Register readback.
   input wire logic [1:0] rd_kind,
   input wire logic [1:0] rd_chan,
   output logic [15:0] rd_data
);
   import dfd_pkg::*;

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   function automatic logic [1:0] kind_of(input logic [2:0] sel);
      case (sel)
         SEL_GAIN, SEL_GAIN_ALL: kind_of = KIND_GAIN;
         SEL_OFFS, SEL_OFFS_ALL: kind_of = KIND_OFFS;
         SEL_CLEAR: kind_of = KIND_CLEAR;
         default: kind_of = KIND_DATA;
      endcase
   endfunction : kind_of

   // ----------------------------------------------------------------
   // Reset release and pin synchronisers
   // ----------------------------------------------------------------
   logic rst_s1_r, rst_n;
   logic sync_s1_r, sync_s2_r, sync_s3_r;
   logic [2:0] pin_s1_r, pin_s2_r;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_s1_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n <= rst_s1_r;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_s1_r <= 1'b1;
         sync_s2_r <= 1'b1;
         sync_s3_r <= 1'b1;
         pin_s1_r <= 3'h0;
         pin_s2_r <= 3'h0;
      end else begin
         sync_s1_r <= link_sync_n;
         sync_s2_r <= sync_s1_r;
         sync_s3_r <= sync_s2_r;
         pin_s1_r <= {address_strap_hi, address_strap_lo, packet_checksum};
         pin_s2_r <= pin_s1_r;
      end
   end

   // ----------------------------------------------------------------
   // Link domain shift register
   // ----------------------------------------------------------------
   logic link_clr_n_r;
   logic [31:0] shift_r, shift_nxt;
   logic [5:0] cnt_r, cnt_nxt;
   always_comb begin
      shift_nxt = {shift_r[SHIFT_BITS-2:0], link_sdin};
      cnt_nxt = (cnt_r == 6'h3F) ? cnt_r : cnt_r + 6'h01;
   end
   // The shifter is held clear while the frame signal stands high, so
   // every frame starts from an empty count without needing a link edge.
   always_ff @(posedge link_sclk or negedge link_clr_n_r) begin
      if (!link_clr_n_r) begin
         shift_r <= 32'h0000_0000;
         cnt_r <= 6'h00;
      end else begin
         shift_r <= shift_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         link_clr_n_r <= 1'b0;
      end else begin
         link_clr_n_r <= ~sync_s2_r;
      end
   end

   // ----------------------------------------------------------------
   // Frame capture
   // ----------------------------------------------------------------
   logic cap_valid_r, cap_valid_nxt, cap_len_ok_r, cap_len_ok_nxt, frame_end;
   logic [23:0] cap_frame_r, cap_frame_nxt;
   logic [7:0] csum_r, csum_nxt;
   assign frame_end = sync_s2_r & ~sync_s3_r;
   always_comb begin
      cap_valid_nxt = frame_end;
      cap_len_ok_nxt = cap_len_ok_r;
      cap_frame_nxt = cap_frame_r;
      csum_nxt = csum_r;
      if (frame_end) begin
         if (pin_s2_r[0]) begin
            cap_len_ok_nxt = (cnt_r == 6'(CSUM_FRAME_BITS));
            cap_frame_nxt = shift_r[SHIFT_BITS-1:CSUM_BITS];
            csum_nxt = shift_r[CSUM_BITS-1:0];
         end else begin
            cap_len_ok_nxt = (cnt_r == 6'(FRAME_BITS));
            cap_frame_nxt = shift_r[FRAME_BITS-1:0];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cap_valid_r <= 1'b0;
         cap_len_ok_r <= 1'b0;
         cap_frame_r <= 24'h000000;
         csum_r <= 8'h00;
      end else begin
         cap_valid_r <= cap_valid_nxt;
         cap_len_ok_r <= cap_len_ok_nxt;
         cap_frame_r <= cap_frame_nxt;
         csum_r <= csum_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Frame decode and register writes
   // ----------------------------------------------------------------
   logic f_rw;
   logic [1:0] f_dev, f_ch;
   logic [2:0] f_sel;
   logic [15:0] f_data;
   assign f_rw = cap_frame_r[RW_BIT];
   assign f_dev = cap_frame_r[DEVSEL_HI:DEVSEL_LO];
   assign f_sel = cap_frame_r[REGSEL_HI:REGSEL_LO];
   assign f_ch = cap_frame_r[CHSEL_HI:CHSEL_LO];
   assign f_data = cap_frame_r[DATA_HI:0];
   dfd_state_t state_r, state_nxt;
   logic [1:0] bcnt_r, bcnt_nxt, bkind_r, bkind_nxt, ctrl_chan_r;
   logic [1:0] wr_kind, wr_chan, wr_kind_r, wr_chan_r, ctrl_chan_nxt;
   logic [15:0] bdata_r, bdata_nxt, ctrl_data_nxt, ctrl_data_r;
   logic [15:0] wr_data, wr_data_r;
   logic wr_en, wr_en_r, ctrl_nxt, rej_nxt, rd_nxt, rej_r, rd_r, ctrl_r;
   logic [3:0] cal_start;
   always_comb begin
      state_nxt = state_r;
      bcnt_nxt = bcnt_r;
      bkind_nxt = bkind_r;
      bdata_nxt = bdata_r;
      wr_en = 1'b0;
      wr_kind = kind_of(f_sel);
      wr_chan = f_ch;
      wr_data = f_data;
      cal_start = 4'h0;
      ctrl_nxt = 1'b0;
      ctrl_chan_nxt = ctrl_chan_r;
      ctrl_data_nxt = ctrl_data_r;
      rej_nxt = 1'b0;
      rd_nxt = 1'b0;
      case (state_r)
         DFD_IDLE: begin
            if (cap_valid_r) begin
               if (!cap_len_ok_r) begin
                  rej_nxt = 1'b1;
               end else if (f_dev != pin_s2_r[2:1]) begin
                  rej_nxt = 1'b1;
               end else if (f_rw) begin
                  rd_nxt = 1'b1;
               end else begin
                  case (f_sel)
                     SEL_DATA: begin
                        wr_en = 1'b1;
                        cal_start[f_ch] = 1'b1;
                     end
                     SEL_GAIN, SEL_OFFS, SEL_CLEAR: begin
                        wr_en = 1'b1;
                     end
                     SEL_GAIN_ALL, SEL_OFFS_ALL: begin
                        state_nxt = DFD_BCAST;
                        bcnt_nxt = 2'h0;
                        bkind_nxt = kind_of(f_sel);
                        bdata_nxt = f_data;
                     end
                     SEL_CTRL: begin
                        ctrl_nxt = 1'b1;
                        ctrl_chan_nxt = f_ch;
                        ctrl_data_nxt = f_data;
                     end
                     default: begin
                        rej_nxt = 1'b1;
                     end
                  endcase
               end
            end
         end
         DFD_BCAST: begin
            wr_en = 1'b1;
            wr_kind = bkind_r;
            wr_chan = bcnt_r;
            wr_data = bdata_r;
            bcnt_nxt = bcnt_r + 2'h1;
            if (bcnt_r == 2'h3) begin
               state_nxt = DFD_IDLE;
            end
         end
         default: begin
            state_nxt = DFD_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= DFD_IDLE;
         bcnt_r <= 2'h0;
         bkind_r <= 2'h0;
         bdata_r <= 16'h0000;
         ctrl_r <= 1'b0;
         ctrl_chan_r <= 2'h0;
         ctrl_data_r <= 16'h0000;
         rej_r <= 1'b0;
         rd_r <= 1'b0;
         wr_en_r <= 1'b0;
         wr_kind_r <= 2'h0;
         wr_chan_r <= 2'h0;
         wr_data_r <= 16'h0000;
      end else begin
         state_r <= state_nxt;
         bcnt_r <= bcnt_nxt;
         bkind_r <= bkind_nxt;
         bdata_r <= bdata_nxt;
         ctrl_r <= ctrl_nxt;
         ctrl_chan_r <= ctrl_chan_nxt;
         ctrl_data_r <= ctrl_data_nxt;
         rej_r <= rej_nxt;
         rd_r <= rd_nxt;
         wr_en_r <= wr_en;
         wr_kind_r <= wr_kind;
         wr_chan_r <= wr_chan;
         wr_data_r <= wr_data;
      end
   end

   dfd_regbank u_regbank (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .wr_en(wr_en_r),
      .wr_kind(wr_kind_r),
      .wr_chan(wr_chan_r),
      .wr_data(wr_data_r),
      .rd_kind(rd_kind),
      .rd_chan(rd_chan),
      .rd_data(rd_data)
   );

   // ----------------------------------------------------------------
   // Per channel calibration and settle timers
   // ----------------------------------------------------------------
   genvar gc;
   generate
      for (gc = 0; gc < NUM_CH; gc++) begin : g_ch
         logic [15:0] cal_r, cal_nxt, set_r, set_nxt;
         always_comb begin
            cal_nxt = (cal_r != 16'h0000) ? cal_r - 16'h0001 : cal_r;
            set_nxt = (set_r != 16'h0000) ? set_r - 16'h0001 : set_r;
            if (cal_start[gc]) begin
               cal_nxt = 16'(CAL_CYCLES);
               set_nxt = 16'(SETTLE_CYCLES);
            end
         end
         always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               cal_r <= 16'h0000;
               set_r <= 16'h0000;
            end else begin
               cal_r <= cal_nxt;
               set_r <= set_nxt;
            end
         end
         assign cal_busy[gc] = (cal_r != 16'h0000);
         assign output_enable_safe[gc] = (set_r == 16'h0000);
      end
   endgenerate

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign ctrl_wr_pulse = ctrl_r;
   assign ctrl_wr_chan = ctrl_chan_r;
   assign ctrl_wr_data = ctrl_data_r;
   assign frame_rejected = rej_r;
   assign read_req = rd_r;
   assign frame_checksum_code = csum_r;

endmodule : dfd_frame_decode

/* File: logic/dfd_regbank.sv */
`timescale 1ns/1ps
module dfd_regbank (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst_n,
   // Write port.
   input wire logic wr_en,
   input wire logic [1:0] wr_kind,
   input wire logic [1:0] wr_chan,
   input wire logic [15:0] wr_data,
   // Read port.
   input wire logic [1:0] rd_kind,
   input wire logic [1:0] rd_chan,
   output logic [15:0] rd_data
);
   import dfd_pkg::*;

   function automatic logic [15:0] rst_val(input int idx);
      logic [1:0] k;
      k = 2'(idx / NUM_CH);
      case (k)
         KIND_GAIN: rst_val = GAIN_RST;
         KIND_OFFS: rst_val = OFFS_RST;
         KIND_CLEAR: rst_val = CLEAR_RST;
         default: rst_val = DATA_RST;
      endcase
   endfunction : rst_val

   logic [15:0] mem_r [16];
   logic [15:0] rd_data_r;

   genvar gi;
   generate
      for (gi = 0; gi < 16; gi++) begin : g_word
         always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               mem_r[gi] <= rst_val(gi);
            end else if (wr_en && {wr_kind, wr_chan} == 4'(gi)) begin
               mem_r[gi] <= wr_data;
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_r <= 16'h0000;
      end else begin
         rd_data_r <= mem_r[{rd_kind, rd_chan}];
      end
   end

   assign rd_data = rd_data_r;

endmodule : dfd_regbank

/* File: pkg/dfd_pkg.sv */
package dfd_pkg;

   // ----------------------------------------------------------------
   // Frame layout
   // ----------------------------------------------------------------
   localparam int FRAME_BITS = 24;
   localparam int CSUM_FRAME_BITS = 32;
   localparam int CSUM_BITS = 8;
   localparam int SHIFT_BITS = 32;
   localparam int CNT_BITS = 6;
   localparam int RW_BIT = 23;
   localparam int DEVSEL_HI = 22;
   localparam int DEVSEL_LO = 21;
   localparam int REGSEL_HI = 20;
   localparam int REGSEL_LO = 18;
   localparam int CHSEL_HI = 17;
   localparam int CHSEL_LO = 16;
   localparam int DATA_HI = 15;
   localparam int DATA_W = 16;
   localparam int NUM_CH = 4;

   // ----------------------------------------------------------------
   // Register select codes
   // ----------------------------------------------------------------
   localparam logic [2:0] SEL_DATA = 3'h0;
   localparam logic [2:0] SEL_GAIN = 3'h2;
   localparam logic [2:0] SEL_GAIN_ALL = 3'h3;
   localparam logic [2:0] SEL_OFFS = 3'h4;
   localparam logic [2:0] SEL_OFFS_ALL = 3'h5;
   localparam logic [2:0] SEL_CLEAR = 3'h6;
   localparam logic [2:0] SEL_CTRL = 3'h7;

   // ----------------------------------------------------------------
   // Register bank kinds and reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] KIND_DATA = 2'h0;
   localparam logic [1:0] KIND_GAIN = 2'h1;
   localparam logic [1:0] KIND_OFFS = 2'h2;
   localparam logic [1:0] KIND_CLEAR = 2'h3;
   localparam logic [15:0] DATA_RST = 16'h0000;
   localparam logic [15:0] GAIN_RST = 16'hFFFF;
   localparam logic [15:0] OFFS_RST = 16'h0000;
   localparam logic [15:0] CLEAR_RST = 16'h0000;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int SYS_CLK_HZ = 40000000;
   localparam int SETTLE_TIME_US = 200;
   localparam int SETTLE_CYCLES = (SETTLE_TIME_US * (SYS_CLK_HZ / 1000))
                                  / 1000;
   localparam int CAL_TIME_NS = 1000;
   localparam int CAL_CYCLES = (CAL_TIME_NS * (SYS_CLK_HZ / 1000000)
                                + 999) / 1000;
   localparam int TIMER_W = 16;

   typedef enum {DFD_IDLE, DFD_BCAST} dfd_state_t;

endpackage : dfd_pkg

/* File: tb/dfd_frame_decode_sva.sv */
`timescale 1ns/1ps
module dfd_frame_decode_sva #(
   parameter int SETTLE_CYCLES = 8000,
   parameter int CAL_CYCLES = 40
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic arst_n,
   // Observed signals.
   input wire logic link_sync_n,
   input wire logic ctrl_wr_pulse,
   input wire logic [1:0] ctrl_wr_chan,
   input wire logic [15:0] ctrl_wr_data,
   input wire logic frame_rejected,
   input wire logic read_req,
   input wire logic [3:0] cal_busy,
   input wire logic [3:0] output_enable_safe
);
   int cal_r;
   int cal_nxt;
   int low_r;
   int low_nxt;
   logic any_p;
   always_comb begin
      cal_nxt = cal_busy[0] ? cal_r + 1 : 0;
      low_nxt = output_enable_safe[0] ? 0 : low_r + 1;
      any_p = ctrl_wr_pulse | frame_rejected | read_req;
   end
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cal_r <= 0;
         low_r <= 0;
      end else begin
         cal_r <= cal_nxt;
         low_r <= low_nxt;
      end
   end
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);
   sequence s_cal_on;
      $rose(cal_busy[0]) ##1 cal_busy[0];
   endsequence
   a_ctrl_one: assert property (ctrl_wr_pulse |=> !ctrl_wr_pulse)
      else $error("control pulse too long");
   a_rej_one: assert property (frame_rejected |=> !frame_rejected)
      else $error("reject pulse too long");
   a_read_one: assert property (read_req |=> !read_req)
      else $error("read pulse too long");
   a_pulse_excl: assert property (
      $onehot0({ctrl_wr_pulse, frame_rejected, read_req}))
      else $error("two results for one frame");
   a_pulse_after: assert property (
      any_p |-> link_sync_n && $past(link_sync_n, 4))
      else $error("result without closed frame");
   a_ctrl_hold: assert property (
      !ctrl_wr_pulse |-> $stable(ctrl_wr_data) && $stable(ctrl_wr_chan))
      else $error("control data changed without write");
   a_cal_len: assert property (
      $fell(cal_busy[0]) |-> cal_r == CAL_CYCLES)
      else $error("calibration length wrong");
   a_settle_len: assert property (
      $rose(output_enable_safe[0]) |-> low_r == SETTLE_CYCLES)
      else $error("settle length wrong");
   a_cal_in_settle: assert property (
      s_cal_on |-> !output_enable_safe[0])
      else $error("output safe during calibration");
endmodule : dfd_frame_decode_sva
bind dfd_frame_decode dfd_frame_decode_sva #(
   .SETTLE_CYCLES(SETTLE_CYCLES), .CAL_CYCLES(CAL_CYCLES)
) i_dfd_frame_decode_sva (
   .sys_clk(sys_clk), .arst_n(arst_n), .link_sync_n(link_sync_n),
   .ctrl_wr_pulse(ctrl_wr_pulse), .ctrl_wr_chan(ctrl_wr_chan),
   .ctrl_wr_data(ctrl_wr_data), .frame_rejected(frame_rejected),
   .read_req(read_req), .cal_busy(cal_busy),
   .output_enable_safe(output_enable_safe)
);

/* File: tb/dfd_host_model.sv */
`timescale 1ns/1ps
module dfd_host_model #(
   parameter int WAIT_NS = 200000,
   parameter logic [15:0] CTRL_INT_ON = 16'h0010,
   parameter logic [15:0] CTRL_OUT_ON = 16'h0030
) (
   // Serial link.
   output logic link_sclk,
   output logic link_sync_n,
   output logic link_sdin
);
   initial begin
      link_sclk = 1'b0;
      link_sync_n = 1'b1;
      link_sdin = 1'b0;
   end
   function automatic logic [31:0] fr(logic [1:0] d, logic [2:0] s,
                                      logic [1:0] c, logic [15:0] v);
      return {8'h00, 1'b0, d, s, c, v};
   endfunction : fr
   // Sends n bits MSB first; the clock only runs inside the frame.
   task automatic send(input logic [31:0] f, input int n);
      #13.3 link_sync_n = 1'b0;
      #200;
      for (int i = n - 1; i >= 0; i--) begin
         link_sdin = f[i];
         #80 link_sclk = 1'b1;
         #80 link_sclk = 1'b0;
      end
      #80 link_sync_n = 1'b1;
      link_sdin = ~link_sdin;
      #600;
   endtask : send
   task automatic supply_setup(input logic [1:0] d);
      send(fr(d, 3'h7, 2'h0, 16'h0007), 24);
   endtask : supply_setup
   task automatic bring_up(input logic [1:0] d, c, input logic [15:0] v);
      send(fr(d, 3'h7, c, CTRL_INT_ON), 24);
      send(fr(d, 3'h0, c, v), 24);
      #(WAIT_NS);
      send(fr(d, 3'h7, c, CTRL_OUT_ON), 24);
   endtask : bring_up
   task automatic range_change(input logic [1:0] d, c,
                               input logic [15:0] v);
      send(fr(d, 3'h0, c, 16'h0000), 24);
      bring_up(d, c, v);
   endtask : range_change
endmodule : dfd_host_model

/* File: tb/tb_dfd_frame_decode.sv */
`timescale 1ns/1ps
module tb_dfd_frame_decode;
   import dfd_pkg::*;
   localparam int SETTLE = 20;
   localparam logic [15:0] C_ON = 16'h0030;
   logic sys_clk, arst_n, link_sclk, link_sync_n, link_sdin;
   logic st_hi, st_lo, csum_on, ctrl_wr_pulse, frame_rejected, read_req;
   logic [1:0] ctrl_wr_chan, rd_kind, rd_chan;
   logic [15:0] ctrl_wr_data, rd_data;
   logic [7:0] frame_checksum_code;
   logic [3:0] cal_busy, output_enable_safe;
   int n_errors = 0;
   int samples_checked = 0;
   int n_ctrl = 0;
   int n_rej = 0;
   int n_rd = 0;
   dfd_frame_decode #(.SETTLE_CYCLES(SETTLE), .CAL_CYCLES(4))
   i_dfd_frame_decode (
      .sys_clk(sys_clk), .arst_n(arst_n), .link_sclk(link_sclk),
      .link_sync_n(link_sync_n), .link_sdin(link_sdin),
      .address_strap_hi(st_hi), .address_strap_lo(st_lo),
      .packet_checksum(csum_on), .ctrl_wr_pulse(ctrl_wr_pulse),
      .ctrl_wr_chan(ctrl_wr_chan), .ctrl_wr_data(ctrl_wr_data),
      .frame_rejected(frame_rejected), .read_req(read_req),
      .frame_checksum_code(frame_checksum_code), .cal_busy(cal_busy),
      .output_enable_safe(output_enable_safe), .rd_kind(rd_kind),
      .rd_chan(rd_chan), .rd_data(rd_data));
   dfd_host_model #(.WAIT_NS(SETTLE * 25 + 100), .CTRL_OUT_ON(C_ON))
   i_dfd_host_model (.link_sclk(link_sclk), .link_sync_n(link_sync_n),
      .link_sdin(link_sdin));
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (ctrl_wr_pulse === 1'b1) n_ctrl++;
      if (frame_rejected === 1'b1) n_rej++;
      if (read_req === 1'b1) n_rd++;
   end
   function automatic logic [31:0] fr(logic rw, logic [1:0] d,
      logic [2:0] s, logic [1:0] c, logic [15:0] v);
      return {8'h00, rw, d, s, c, v};
   endfunction : fr
   task automatic chk(input logic [31:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic rd(input logic [1:0] k, c, input logic [15:0] exp);
      @(posedge sys_clk) #1;
      rd_kind = k;
      rd_chan = c;
      repeat (2) @(posedge sys_clk);
      #1 chk(rd_data, exp);
   endtask : rd
   task automatic snd(input logic [31:0] f, input int n);
      i_dfd_host_model.send(f, n);
   endtask : snd
   task automatic strap(input logic [1:0] s, input logic p);
      @(posedge sys_clk) #1;
      {st_hi, st_lo} = s;
      csum_on = p;
      repeat (4) @(posedge sys_clk);
   endtask : strap
   task automatic t_reset;
      for (int k = 0; k < 4; k++)
         for (int c = 0; c < 4; c++)
            rd(k, c, (k == 1) ? 16'hFFFF : 16'h0000);
      chk(cal_busy, 4'h0);
      chk(output_enable_safe, 4'hF);
   endtask : t_reset
   task automatic t_bring_up;
      for (int c = 0; c < 4; c++) begin
         strap(c, 1'b0);
         if (c == 0) i_dfd_host_model.supply_setup(c);
         i_dfd_host_model.bring_up(c, c, 16'h1000 + c);
         chk(ctrl_wr_chan, c);
         chk(ctrl_wr_data, C_ON);
      end
      for (int c = 0; c < 4; c++) rd(KIND_DATA, c, 16'h1000 + c);
      chk(n_ctrl, 9);
      strap(2'h0, 1'b0);
      i_dfd_host_model.range_change(2'h0, 2'h0, 16'h2222);
      rd(KIND_DATA, 0, 16'h2222);
      chk(n_ctrl, 11);
      chk(cal_busy, 4'h0);
      chk(output_enable_safe, 4'hF);
   endtask : t_bring_up
   task automatic t_codes;
      strap(2'h2, 1'b0);
      snd(fr(0, 2, SEL_GAIN, 1, 16'h8001), 24);
      rd(KIND_GAIN, 1, 16'h8001);
      rd(KIND_DATA, 1, 16'h1001);
      snd(fr(0, 2, SEL_OFFS, 2, 16'h0123), 24);
      rd(KIND_OFFS, 2, 16'h0123);
      snd(fr(0, 2, SEL_CLEAR, 3, 16'h4444), 24);
      rd(KIND_CLEAR, 3, 16'h4444);
      snd(fr(0, 2, SEL_GAIN_ALL, 0, 16'h7777), 24);
      snd(fr(0, 2, SEL_OFFS_ALL, 1, 16'h0055), 24);
      for (int c = 0; c < 4; c++) begin
         rd(KIND_GAIN, c, 16'h7777);
         rd(KIND_OFFS, c, 16'h0055);
      end
   endtask : t_codes
   task automatic t_reject;
      int b;
      b = n_rej;
      snd(fr(0, 1, SEL_DATA, 1, 16'hDEAD), 24);
      snd(fr(0, 2, 3'h1, 1, 16'hDEAD), 24);
      snd(fr(0, 2, SEL_DATA, 1, 16'hDEAD), 23);
      snd(fr(0, 2, SEL_DATA, 1, 16'hDEAD) << 1, 25);
      chk(n_rej, b + 4);
      rd(KIND_DATA, 1, 16'h1001);
      b = n_rd;
      snd(fr(1, 2, SEL_DATA, 1, 16'hBEEF), 24);
      chk(n_rd, b + 1);
      rd(KIND_DATA, 1, 16'h1001);
   endtask : t_reject
   task automatic t_csum;
      int b;
      strap(2'h3, 1'b1);
      snd((fr(0, 3, SEL_DATA, 2, 16'hABCD) << 8) | 32'hA5, 32);
      rd(KIND_DATA, 2, 16'hABCD);
      chk(frame_checksum_code, 8'hA5);
      b = n_rej;
      snd(fr(0, 3, SEL_DATA, 2, 16'h1111), 24);
      chk(n_rej, b + 1);
      rd(KIND_DATA, 2, 16'hABCD);
   endtask : t_csum
   task automatic final_report;
      if (n_errors == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : final_report
   initial begin
      #2000000;
      n_errors++;
      final_report;
   end
   initial begin
      arst_n = 1'b0;
      {st_hi, st_lo, csum_on} = 3'h0;
      rd_kind = 2'h0;
      rd_chan = 2'h0;
      repeat (5) @(posedge sys_clk);
      #1 arst_n = 1'b1;
      repeat (4) @(posedge sys_clk);
      t_reset;
      t_bring_up;
      t_codes;
      t_reject;
      t_csum;
      final_report;
   end
endmodule : tb_dfd_frame_decode
